// ---- inc/encoder_spi_pkg.sv ----
// Notes on behaviour
// - Mode 3 link: clock idles high, both ends sample data on rising edge.
// - Four wires: master clock, master data in, slave data out, chip select low.
// - Every frame is exactly sixteen bits; decoding uses that fixed length.
// - Response to previous command shifts out while the next command shifts in.
// - Rate limit 3 bits resets 0; lines per turn code 10 bits resets 1023.
// - Zero position 16 bits resets 0; rotation sense bit resets 1 (forward).
// - Index pulse width and phase, 2 bits each, both reset 0.
// - High field threshold 3 bits resets 7; low field threshold resets 0.
// - Gain adjust 8 bits resets 2; X reduce resets 0, Y reduce resets 1.
// - Read: opcode, 6-bit address, zeros; next frame returns value then zero byte.
// - Write: opcode 10, address, value, MSB first; next frame echoes new value.
// - Command 0xe802 sets write lock; reads and writes refused until reset.
package encoder_spi_pkg;

    // Frame shape and commands
    localparam logic [3:0]  FRAME_LAST = 4'hf;
    localparam logic [1:0]  OP_READ    = 2'h1;
    localparam logic [1:0]  OP_WRITE   = 2'h2;
    localparam logic [15:0] LOCK_CMD   = 16'he802;
    localparam logic [7:0]  PAD_BYTE   = 8'h00;

    // Pin synchroniser lanes and idle levels
    localparam int         SCLK_IDX  = 0;
    localparam int         MOSI_IDX  = 1;
    localparam int         CS_IDX    = 2;
    localparam logic [2:0] SYNC_IDLE = 3'h7;

    // Serial register addresses
    localparam logic [5:0] A_ZERO_LO  = 6'h00;
    localparam logic [5:0] A_ZERO_HI  = 6'h01;
    localparam logic [5:0] A_RATE     = 6'h02;
    localparam logic [5:0] A_LINES_HI = 6'h03;
    localparam logic [5:0] A_LINES_LO = 6'h04;
    localparam logic [5:0] A_DIR      = 6'h05;
    localparam logic [5:0] A_INDEX    = 6'h06;
    localparam logic [5:0] A_FIELD    = 6'h07;
    localparam logic [5:0] A_GAIN     = 6'h08;
    localparam logic [5:0] A_TRIM     = 6'h09;

    // Bus register byte offsets
    localparam logic [4:0] OFF_STATUS = 5'h00;
    localparam logic [4:0] OFF_MASK   = 5'h04;
    localparam logic [4:0] OFF_ANGLE  = 5'h08;
    localparam logic [4:0] OFF_STATE  = 5'h0c;
    localparam logic [4:0] OFF_CFG0   = 5'h10;
    localparam logic [4:0] OFF_CFG1   = 5'h14;

    // Status bits
    localparam int ST_FRAME  = 0;
    localparam int ST_WRITE  = 1;
    localparam int ST_LOCK   = 2;
    localparam int ST_REFUSE = 3;
    localparam int STAT_W    = 4;

    typedef struct packed {
        logic [2:0]  incremental_rate_limit;
        logic [7:0]  sensitivity_gain_adjust;
        logic        reduce_x;
        logic        reduce_y;
        logic [2:0]  field_high;
        logic [2:0]  field_low;
        logic [9:0]  lines_per_turn_code;
        logic        rotation_forward;
        logic [15:0] zero_position;
        logic [1:0]  index_pulse_width;
        logic [1:0]  index_pulse_phase;
    } cfg_t;

    localparam cfg_t CFG_RESET = '{
        incremental_rate_limit:  3'h0,
        sensitivity_gain_adjust: 8'h02,
        reduce_x:                1'h0,
        reduce_y:                1'h1,
        field_high:              3'h7,
        field_low:               3'h0,
        lines_per_turn_code:     10'h3ff,
        rotation_forward:        1'h1,
        zero_position:           16'h0000,
        index_pulse_width:       2'h0,
        index_pulse_phase:       2'h0
    };

endpackage

// ---- hw/angle_encoder_spi_config_port.sv ----
`timescale 1ns/10ps
module angle_encoder_spi_config_port (
    input  wire logic                 clk_in,               // 250 MHz core clock
    input  wire logic                 rst_in,               // Sync reset, active high
    input  wire logic                 ce_in,                // Clock enable, freezes state
    input  wire logic                 sclk_in,              // Serial clock from master
    input  wire logic                 mosi_in,              // Serial data from master
    input  wire logic                 chip_select_low_in,   // Frame select, active low
    output logic                      miso_out,             // Serial data to master
    output logic                      miso_oe_out,          // High while driving miso
    input  wire logic [4:0]           avs_address_in,       // Byte address
    input  wire logic                 avs_read_in,          // Read request
    input  wire logic                 avs_write_in,         // Write request
    input  wire logic [31:0]          avs_writedata_in,     // Write data
    input  wire logic [3:0]           avs_byteenable_in,    // Byte lanes
    output logic [31:0]               avs_readdata_out,     // Read data
    output logic                      avs_waitrequest_out,  // Stall
    output logic                      irq_out,              // Level interrupt
    output logic                      config_write_lock_out, // Lock state
    output encoder_spi_pkg::cfg_t     cfg_out               // Live configuration
);

    // Serial register readback
    function automatic logic [7:0] reg_read(encoder_spi_pkg::cfg_t c, logic [5:0] a);
        case (a)
            encoder_spi_pkg::A_ZERO_LO:  reg_read = c.zero_position[7:0];
            encoder_spi_pkg::A_ZERO_HI:  reg_read = c.zero_position[15:8];
            encoder_spi_pkg::A_RATE:     reg_read = {5'h00, c.incremental_rate_limit};
            encoder_spi_pkg::A_LINES_HI: reg_read = {6'h00, c.lines_per_turn_code[9:8]};
            encoder_spi_pkg::A_LINES_LO: reg_read = c.lines_per_turn_code[7:0];
            encoder_spi_pkg::A_DIR:      reg_read = {7'h00, c.rotation_forward};
            encoder_spi_pkg::A_INDEX:    reg_read = {4'h0, c.index_pulse_phase,
                                                     c.index_pulse_width};
            encoder_spi_pkg::A_FIELD:    reg_read = {2'h0, c.field_high, c.field_low};
            encoder_spi_pkg::A_GAIN:     reg_read = c.sensitivity_gain_adjust;
            encoder_spi_pkg::A_TRIM:     reg_read = {6'h00, c.reduce_y, c.reduce_x};
            default:                     reg_read = 8'h00;
        endcase
    endfunction

    // Serial register update
    function automatic encoder_spi_pkg::cfg_t reg_write(encoder_spi_pkg::cfg_t c,
                                                        logic [5:0] a, logic [7:0] d);
        reg_write = c;
        case (a)
            encoder_spi_pkg::A_ZERO_LO:  reg_write.zero_position[7:0] = d;
            encoder_spi_pkg::A_ZERO_HI:  reg_write.zero_position[15:8] = d;
            encoder_spi_pkg::A_RATE:     reg_write.incremental_rate_limit = d[2:0];
            encoder_spi_pkg::A_LINES_HI: reg_write.lines_per_turn_code[9:8] = d[1:0];
            encoder_spi_pkg::A_LINES_LO: reg_write.lines_per_turn_code[7:0] = d;
            encoder_spi_pkg::A_DIR:      reg_write.rotation_forward = d[0];
            encoder_spi_pkg::A_INDEX: begin
                reg_write.index_pulse_width = d[1:0];
                reg_write.index_pulse_phase = d[3:2];
            end
            encoder_spi_pkg::A_FIELD: begin
                reg_write.field_low  = d[2:0];
                reg_write.field_high = d[5:3];
            end
            encoder_spi_pkg::A_GAIN:     reg_write.sensitivity_gain_adjust = d;
            encoder_spi_pkg::A_TRIM: begin
                reg_write.reduce_x = d[0];
                reg_write.reduce_y = d[1];
            end
            default: reg_write = c;
        endcase
    endfunction

    // Byte-lane merge for bus writes
    function automatic logic [31:0] be_merge(logic [31:0] o, logic [31:0] n, logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            be_merge[i*8 +: 8] = be[i] ? n[i*8 +: 8] : o[i*8 +: 8];
        end
    endfunction

    logic [2:0]  s1_reg, s2_reg, s3_reg, lvl_reg;
    logic [2:0]  s1_next, s2_next, s3_next, lvl_next;
    logic        sclk_rise, sclk_fall, cs_fall, cs_high;
    logic [3:0]  bit_cnt_reg, bit_cnt_next;
    logic        active_reg, active_next;
    logic [15:0] rx_reg, rx_next, tx_reg, tx_next, resp_reg, resp_next;
    logic        miso_next, miso_oe_next;
    logic        frame_end;
    logic [15:0] word;
    encoder_spi_pkg::cfg_t cfg_reg, cfg_next;
    logic        lock_reg, lock_next;
    logic [encoder_spi_pkg::STAT_W-1:0] events;
    logic [encoder_spi_pkg::STAT_W-1:0] status_reg, status_next, mask_reg, mask_next;
    logic [15:0] angle_reg, angle_next;
    logic        wait_reg, wait_next, irq_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [31:0] mask_merge, angle_merge;

    // Pin synchroniser: three stages, level updates when stages two and three agree
    always_comb begin
        s1_next  = {chip_select_low_in, mosi_in, sclk_in};
        s2_next  = s1_reg;
        s3_next  = s2_reg;
        lvl_next = lvl_reg;
        for (int i = 0; i < 3; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                lvl_next[i] = s3_reg[i];
            end
        end
        sclk_rise = ce_in && !lvl_reg[encoder_spi_pkg::SCLK_IDX]
                    && lvl_next[encoder_spi_pkg::SCLK_IDX];
        sclk_fall = ce_in && lvl_reg[encoder_spi_pkg::SCLK_IDX]
                    && !lvl_next[encoder_spi_pkg::SCLK_IDX];
        cs_fall   = ce_in && lvl_reg[encoder_spi_pkg::CS_IDX]
                    && !lvl_next[encoder_spi_pkg::CS_IDX];
        cs_high   = lvl_next[encoder_spi_pkg::CS_IDX];
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s1_reg  <= encoder_spi_pkg::SYNC_IDLE;
            s2_reg  <= encoder_spi_pkg::SYNC_IDLE;
            s3_reg  <= encoder_spi_pkg::SYNC_IDLE;
            lvl_reg <= encoder_spi_pkg::SYNC_IDLE;
        end else if (ce_in) begin
            s1_reg  <= s1_next;
            s2_reg  <= s2_next;
            s3_reg  <= s3_next;
            lvl_reg <= lvl_next;
        end
    end

    // Frame shifter, command decode and configuration store
    always_comb begin
        bit_cnt_next = bit_cnt_reg;
        active_next  = active_reg;
        rx_next      = rx_reg;
        tx_next      = tx_reg;
        resp_next    = resp_reg;
        miso_next    = miso_out;
        miso_oe_next = miso_oe_out;
        cfg_next     = cfg_reg;
        lock_next    = lock_reg;
        events       = '0;
        frame_end    = 1'b0;
        word         = {rx_reg[14:0], lvl_next[encoder_spi_pkg::MOSI_IDX]};
        if (cs_high) begin
            bit_cnt_next = '0;
            active_next  = 1'b0;
            miso_oe_next = 1'b0;
        end else if (cs_fall) begin
            tx_next      = resp_reg;
            miso_next    = resp_reg[15];
            miso_oe_next = 1'b1;
            bit_cnt_next = '0;
            active_next  = 1'b1;
        end else begin
            if (sclk_fall && active_reg) begin
                miso_next = tx_reg[15];
                tx_next   = {tx_reg[14:0], 1'b0};
            end
            if (sclk_rise && active_reg) begin
                rx_next = word;
                if (bit_cnt_reg == encoder_spi_pkg::FRAME_LAST) begin
                    frame_end   = 1'b1;
                    active_next = 1'b0;
                end else begin
                    bit_cnt_next = bit_cnt_reg + 4'h1;
                end
            end
        end
        if (frame_end) begin
            events[encoder_spi_pkg::ST_FRAME] = 1'b1;
            resp_next = angle_reg;
            if (word == encoder_spi_pkg::LOCK_CMD) begin
                lock_next = 1'b1;
                events[encoder_spi_pkg::ST_LOCK] = 1'b1;
            end else if (word[15:14] == encoder_spi_pkg::OP_WRITE) begin
                if (lock_reg) begin
                    events[encoder_spi_pkg::ST_REFUSE] = 1'b1;
                end else begin
                    cfg_next  = reg_write(cfg_reg, word[13:8], word[7:0]);
                    resp_next = {reg_read(cfg_next, word[13:8]), encoder_spi_pkg::PAD_BYTE};
                    events[encoder_spi_pkg::ST_WRITE] = 1'b1;
                end
            end else if (word[15:14] == encoder_spi_pkg::OP_READ) begin
                if (lock_reg) begin
                    events[encoder_spi_pkg::ST_REFUSE] = 1'b1;
                end else begin
                    resp_next = {reg_read(cfg_reg, word[13:8]), encoder_spi_pkg::PAD_BYTE};
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bit_cnt_reg           <= '0;
            active_reg            <= 1'b0;
            rx_reg                <= '0;
            tx_reg                <= '0;
            resp_reg              <= '0;
            miso_out              <= 1'b0;
            miso_oe_out           <= 1'b0;
            cfg_reg               <= encoder_spi_pkg::CFG_RESET;
            cfg_out               <= encoder_spi_pkg::CFG_RESET;
            lock_reg              <= 1'b0;
            config_write_lock_out <= 1'b0;
        end else if (ce_in) begin
            bit_cnt_reg           <= bit_cnt_next;
            active_reg            <= active_next;
            rx_reg                <= rx_next;
            tx_reg                <= tx_next;
            resp_reg              <= resp_next;
            miso_out              <= miso_next;
            miso_oe_out           <= miso_oe_next;
            cfg_reg               <= cfg_next;
            cfg_out               <= cfg_next;
            lock_reg              <= lock_next;
            config_write_lock_out <= lock_next;
        end
    end

    // Bus slave: one wait cycle, then answer; status cleared by its read
    always_comb begin
        wait_next   = 1'b1;
        rdata_next  = rdata_reg;
        mask_next   = mask_reg;
        angle_next  = angle_reg;
        status_next = status_reg;
        mask_merge  = be_merge(32'(mask_reg), avs_writedata_in, avs_byteenable_in);
        angle_merge = be_merge(32'(angle_reg), avs_writedata_in, avs_byteenable_in);
        if ((avs_read_in || avs_write_in) && wait_reg) begin
            wait_next  = 1'b0;
            rdata_next = '0;
            case (avs_address_in)
                encoder_spi_pkg::OFF_STATUS: rdata_next = 32'(status_reg);
                encoder_spi_pkg::OFF_MASK:   rdata_next = 32'(mask_reg);
                encoder_spi_pkg::OFF_ANGLE:  rdata_next = 32'(angle_reg);
                encoder_spi_pkg::OFF_STATE:  rdata_next = 32'({bit_cnt_reg, active_reg,
                                                               lock_reg});
                encoder_spi_pkg::OFF_CFG0:   rdata_next = 32'({cfg_reg.rotation_forward,
                                                               cfg_reg.incremental_rate_limit,
                                                               cfg_reg.lines_per_turn_code,
                                                               cfg_reg.zero_position});
                encoder_spi_pkg::OFF_CFG1:   rdata_next = 32'({cfg_reg.field_high,
                                                               cfg_reg.field_low,
                                                               cfg_reg.index_pulse_phase,
                                                               cfg_reg.index_pulse_width,
                                                               cfg_reg.reduce_y,
                                                               cfg_reg.reduce_x,
                                                               cfg_reg.sensitivity_gain_adjust});
                default:                     rdata_next = '0;
            endcase
        end
        if (!wait_reg && avs_read_in && avs_address_in == encoder_spi_pkg::OFF_STATUS) begin
            status_next = status_reg & ~rdata_reg[encoder_spi_pkg::STAT_W-1:0];
        end
        if (!wait_reg && avs_write_in) begin
            if (avs_address_in == encoder_spi_pkg::OFF_MASK) begin
                mask_next = mask_merge[encoder_spi_pkg::STAT_W-1:0];
            end
            if (avs_address_in == encoder_spi_pkg::OFF_ANGLE) begin
                angle_next = angle_merge[15:0];
            end
        end
        status_next = status_next | events;
        irq_next    = |(status_next & mask_next);
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wait_reg            <= 1'b1;
            avs_waitrequest_out <= 1'b1;
            rdata_reg           <= '0;
            avs_readdata_out    <= '0;
            mask_reg            <= '0;
            angle_reg           <= '0;
            status_reg          <= '0;
            irq_out             <= 1'b0;
        end else if (ce_in) begin
            wait_reg            <= wait_next;
            avs_waitrequest_out <= wait_next;
            rdata_reg           <= rdata_next;
            avs_readdata_out    <= rdata_next;
            mask_reg            <= mask_next;
            angle_reg           <= angle_next;
            status_reg          <= status_next;
            irq_out             <= irq_next;
        end
    end

    // Checks on the serial port and bus
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    chk_idle_quiet: assert property (ce_in && cs_high |=> !miso_oe_out)
        else $error("miso driven outside frame");
    chk_count_clear: assert property (ce_in && cs_high |=> bit_cnt_reg == 4'h0)
        else $error("bit counter not cleared while deselected");
    chk_frame_len: assert property (frame_end |-> bit_cnt_reg == encoder_spi_pkg::FRAME_LAST)
        else $error("frame ended at wrong bit count");
    chk_rise_only: assert property ((bit_cnt_reg != $past(bit_cnt_reg)) && bit_cnt_reg != 4'h0
                                    |-> $past(sclk_rise))
        else $error("bit counted without rising clock");
    chk_load_resp: assert property (cs_fall |=> miso_oe_out && miso_out == $past(resp_reg[15]))
        else $error("response msb not presented at frame start");
    chk_write_ack: assert property (frame_end && !lock_reg
                                    && word[15:14] == encoder_spi_pkg::OP_WRITE
                                    |=> resp_reg == {reg_read(cfg_reg, $past(word[13:8])),
                                                     encoder_spi_pkg::PAD_BYTE})
        else $error("write acknowledge does not echo new value");
    chk_read_pad: assert property (frame_end && !lock_reg
                                   && word[15:14] == encoder_spi_pkg::OP_READ
                                   |=> resp_reg[7:0] == encoder_spi_pkg::PAD_BYTE)
        else $error("read response low byte not zero");
    chk_lock_hold: assert property (lock_reg |=> lock_reg && $stable(cfg_reg))
        else $error("locked configuration changed");
    chk_lock_take: assert property (frame_end && word == encoder_spi_pkg::LOCK_CMD
                                    |=> lock_reg)
        else $error("lock command not taken");
    chk_reset_cfg: assert property ($fell(rst_in) |-> cfg_out == encoder_spi_pkg::CFG_RESET)
        else $error("configuration reset values wrong");
    chk_bus_answer: assert property (ce_in && (avs_read_in || avs_write_in) && wait_reg
                                     |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("bus answer not one cycle after request");

endmodule

// ---- tb/spi_master_model.sv ----
`timescale 1ns/10ps
module spi_master_model (
    input  wire logic   clk_in,     // Core clock
    input  wire logic   miso_in,    // Data from port
    output logic        sclk_out,   // Link clock
    output logic        mosi_out,   // Data to port
    output logic        cs_low_out, // Frame select
    output logic        done_out,   // Full frame seen
    output logic [15:0] rsp_out     // Shifted-in word
);
    logic [15:0] r;
    // Idle: clock high, pulled-up data and select
    initial begin
        sclk_out = 1'b1;
        mosi_out = 1'b1;
        cs_low_out = 1'b1;
        done_out = 1'b0;
        rsp_out = 16'h0000;
        r = 16'h0000;
    end
    // Frame of n bits, MSB first, change on fall, sample on rise
    task automatic frame(input logic [15:0] cmd, input int n);
        cs_low_out <= 1'b0;
        repeat (8) @(posedge clk_in);
        for (int i = 15; i > 15 - n; i--) begin
            sclk_out <= 1'b0;
            mosi_out <= cmd[i];
            repeat (8) @(posedge clk_in);
            sclk_out <= 1'b1;
            r[i] = miso_in;
            repeat (8) @(posedge clk_in);
        end
        repeat (24) @(posedge clk_in);
        cs_low_out <= 1'b1;
        mosi_out <= 1'b1;
        rsp_out <= r;
        done_out <= (n == 16);
        @(posedge clk_in);
        done_out <= 1'b0;
        // Port commits at once, so the settle wait shrinks to a gap
        repeat (12) @(posedge clk_in);
    endtask
endmodule

// ---- tb/angle_encoder_spi_config_port_tb.sv ----
`timescale 1ns/10ps
module angle_encoder_spi_config_port_tb;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [4:0]  adr    = 5'h00;
    logic        rd     = 1'b0;
    logic        wr     = 1'b0;
    logic [31:0] wdat   = 32'h0;
    logic [31:0] rdat;
    logic        wreq, irq, lock, miso, miso_oe, sclk, mosi, cs_low, done;
    logic [15:0] rsp, ang;
    logic [7:0]  g;
    logic [32:0] e;
    logic [32:0] exp_q[$];
    integer      seed = 63506;
    int          bad_count = 0;
    int          samples_checked = 0;
    logic [7:0]  rst_tbl [10] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'hff,
                                  8'h01, 8'h00, 8'h38, 8'h02, 8'h02};
    encoder_spi_pkg::cfg_t cfg;
    // Released data line shows the inverse so stale bits cannot pass
    wire         miso_line = miso_oe ? miso : ~miso;

    always #2 clk_in = ~clk_in;

    angle_encoder_spi_config_port dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1),
        .sclk_in(sclk), .mosi_in(mosi), .chip_select_low_in(cs_low), .miso_out(miso),
        .miso_oe_out(miso_oe), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdat), .avs_byteenable_in(4'hf), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wreq), .irq_out(irq), .config_write_lock_out(lock),
        .cfg_out(cfg));
    spi_master_model m (.clk_in(clk_in), .miso_in(miso_line), .sclk_out(sclk),
        .mosi_out(mosi), .cs_low_out(cs_low), .done_out(done), .rsp_out(rsp));

    task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] y);
        samples_checked++;
        if (x !== y) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, x, y);
        end
    endtask
    // Bus cycle held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        adr <= a;
        rd <= ~w;
        wr <= w;
        wdat <= d;
        do @(posedge clk_in); while (wreq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rdx(input logic [4:0] a, input logic c, input logic [31:0] v);
        exp_q.push_back({c, v});
        bus(1'b0, a, 32'h0);
    endtask
    task automatic sf(input logic [15:0] cmd, input logic c, input logic [15:0] v);
        exp_q.push_back({c, 16'h0, v});
        m.frame(cmd, 16);
    endtask
    task automatic summarize();
        if (bad_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Oldest note matched against each answer as it appears
    always @(posedge clk_in) begin
        if ((rd && wreq === 1'b0) || done === 1'b1) begin
            e = exp_q.pop_front();
            if (e[32])
                cmp(done ? "spi_rsp" : "readdata", e[31:0], done ? {16'h0, rsp} : rdat);
        end
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        rdx(encoder_spi_pkg::OFF_CFG0, 1'b1, 32'h23ff0000);
        rdx(encoder_spi_pkg::OFF_CFG1, 1'b1, 32'h000e0202);
        cmp("cfg_reset", 32'h1, {31'h0, cfg == encoder_spi_pkg::CFG_RESET});
        bus(1'b1, 5'h1c, 32'hffffffff);
        rdx(5'h1c, 1'b1, 32'h0);
        sf(16'h4000, 1'b0, 16'h0);
        for (int a = 1; a < 11; a++) begin
            sf({2'b01, 6'(a), 8'h00}, 1'b1, {rst_tbl[a - 1], 8'h00});
        end
        bus(1'b1, encoder_spi_pkg::OFF_MASK, 32'hf);
        rdx(encoder_spi_pkg::OFF_MASK, 1'b1, 32'hf);
        rdx(encoder_spi_pkg::OFF_STATUS, 1'b0, 32'h0);
        @(posedge clk_in);
        cmp("irq", 32'h0, {31'h0, irq});
        g = 8'($random(seed));
        sf({encoder_spi_pkg::OP_WRITE, encoder_spi_pkg::A_GAIN, g}, 1'b1, 16'h0);
        cmp("irq", 32'h1, {31'h0, irq});
        rdx(encoder_spi_pkg::OFF_STATUS, 1'b1, 32'h3);
        @(posedge clk_in);
        cmp("irq", 32'h0, {31'h0, irq});
        sf({encoder_spi_pkg::OP_READ, encoder_spi_pkg::A_GAIN, 8'h00}, 1'b1, {g, 8'h00});
        ang = 16'($random(seed));
        bus(1'b1, encoder_spi_pkg::OFF_ANGLE, {16'h0, ang});
        rdx(encoder_spi_pkg::OFF_ANGLE, 1'b1, {16'h0, ang});
        sf(16'h0000, 1'b1, {g, 8'h00});
        rdx(encoder_spi_pkg::OFF_CFG1, 1'b1, {24'h000e02, g});
        cmp("cfg_gain", {24'h0, g}, {24'h0, cfg.sensitivity_gain_adjust});
        sf(encoder_spi_pkg::LOCK_CMD, 1'b1, ang);
        sf({encoder_spi_pkg::OP_WRITE, encoder_spi_pkg::A_GAIN, ~g}, 1'b0, 16'h0);
        sf({encoder_spi_pkg::OP_READ, encoder_spi_pkg::A_GAIN, 8'h00}, 1'b1, ang);
        m.frame(16'h8000, 5);
        sf(16'h0000, 1'b1, ang);
        rdx(encoder_spi_pkg::OFF_CFG1, 1'b1, {24'h000e02, g});
        rdx(encoder_spi_pkg::OFF_STATUS, 1'b1, 32'hd);
        cmp("lock", 32'h1, {31'h0, lock});
        cmp("cfg_gain", {24'h0, g}, {24'h0, cfg.sensitivity_gain_adjust});
        rdx(encoder_spi_pkg::OFF_STATE, 1'b1, 32'h1);
        summarize();
    end

    // Watchdog
    initial begin
        repeat (30000) @(posedge clk_in);
        bad_count++;
        summarize();
    end
endmodule
